// >>> src/pccr_pkg.sv
// register map, field layout, reset values and timing counts for the
// transceiver configuration/control register bank.
// assumes one 100 MHz clock; used by pccr_top and pccr_xover through pccr_pkg::
package pccr_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [5:0] CONFIG_THREE_IDX = 6'h1e;
    localparam logic [5:0] SRST_IDX = 6'h1f;
    localparam logic [5:0] TMCH_IDX = 6'h25;
    localparam logic [5:0] RXTM_IDX = 6'h2c;
    localparam logic [5:0] LINK_IDX = 6'h30;
    localparam logic [5:0] IRQS_IDX = 6'h31;
    localparam logic [5:0] IRQM_IDX = 6'h32;
    // config_three fields
    localparam int EXT_FD_BIT = 11;
    localparam int ROBUST_BIT = 9;
    localparam int QUICK_BIT = 8;
    localparam int IRQ_OE_BIT = 7;
    localparam int FORCE_IRQ_BIT = 6;
    localparam int CT_FAIL_BIT = 2;
    localparam int CT_DONE_BIT = 1;
    localparam int CT_START_BIT = 0;
    localparam logic [15:0] CONFIG_THREE_WMASK = 16'h0bc0;
    // soft_reset_control fields
    localparam int FULL_RST_BIT = 15;
    localparam int RESTART_BIT = 14;
    // test_channel_control fields
    localparam logic [15:0] TMCH_RESET = 16'h0400;
    localparam logic [15:0] TMCH_WMASK = 16'hffe0;
    localparam int TM_ALL_BIT = 7;
    // robust crossover timer register
    localparam logic [15:0] RXTM_RESET = 16'h141f;
    localparam int TIMER_STEP_MS = 32;
    localparam int CLK_MHZ = 100;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    // cable test and restart durations
    localparam int CT_RUN_CYCLES = 1000;
    localparam int RESTART_CYCLES = 16;
    // status register bits: test done, test failed, link settled
    localparam int EV_CT_DONE = 0;
    localparam int EV_CT_FAIL = 1;
    localparam int EV_XOVER = 2;
    localparam logic [2:0] EV_MASK_RESET = 3'h0;
    typedef enum logic [1:0]
    {
        CT_IDLE = 2'b00,
        CT_RUN = 2'b01,
        CT_EVAL = 2'b10
    } pccr_ct_state_t;
endpackage

// >>> src/pccr_tick_div.sv
// divider making a one-cycle pulse every DIV cycles.
// assumes core_clk and a synchronous active-high clear.
`timescale 1ns/1ps
module pccr_tick_div
#(
    parameter int DIV = 100000
)
(
    input wire logic core_clk,
    input wire logic clr,
    output logic tick
);
    logic [31:0] cnt_q;
    wire logic atEnd = (cnt_q == 32'(DIV - 1));
    always_ff @(posedge core_clk)
    begin
        if (clr || atEnd)
            cnt_q <= 32'h0;
        else
            cnt_q <= cnt_q + 32'h1;
    end
    always_ff @(posedge core_clk)
    begin
        if (clr)
            tick <= 1'b0;
        else
            tick <= atEnd;
    end
endmodule

// >>> src/pccr_top.sv
// register bank for transceiver configuration, soft reset, test channel
// select and robust crossover timer, on an avalon-mm slave.
// assumes one 100 MHz clock and synchronous active-high sys_rst;
// link and pin inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps
// Functional notes
// - extended duplex forces full against forced-100 partner
// - without it, standard duplex resolution applies
// - robust mode resolves crossover in unsupported cases
// - quick mode shortens crossover when both forced
// - select bit makes shared pin interrupt output
// - force bit asserts interrupt pin whenever the select bit is set
// - reserved bits ignore writes, read zero
// - start launches cable test; done low while running
// - failed flag shows last test failure
// - full reset clears everything, then self-clears
// - restart keeps registers, then self-clears
// - select bit seven drives all four channels
// - bits six-five pick single test channel
// - timer code sets period in 32 ms steps
module pccr_top
#(
    parameter int MS_CYCLES = pccr_pkg::CYC_PER_MS,
    parameter int CT_CYCLES = pccr_pkg::CT_RUN_CYCLES
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_response_err,
    input wire logic irqOrPowerdownIn,
    output logic irqOrPowerdownOut,
    output logic irqOrPowerdownOe,
    output logic powerDown,
    input wire logic cableFault,
    input wire logic selfAutoNeg,
    input wire logic partnerForced100,
    input wire logic partnerFullDuplex,
    input wire logic energySeen,
    input wire logic [2:0] irqSources,
    output logic [3:0] testChannelEn,
    output logic mdixSel,
    output logic fullDuplex,
    output logic phyRestart,
    output logic irq
);
    // input synchronisers: first stage feeds only the second
    logic [7:0] syncA_q;
    logic [7:0] syncB_q;
    wire logic [7:0] rawIn = {irqSources, energySeen, partnerFullDuplex,
        partnerForced100, cableFault, irqOrPowerdownIn};
    always_ff @(posedge core_clk)
    begin
        syncA_q <= rawIn;
        syncB_q <= syncA_q;
    end
    wire logic pinInS = syncB_q[0];
    wire logic faultS = syncB_q[1];
    wire logic pF100S = syncB_q[2];
    wire logic pFdS = syncB_q[3];
    wire logic energyS = syncB_q[4];
    wire logic [2:0] srcS = syncB_q[7:5];
    logic selfAnA_q;
    logic selfAnS_q;
    always_ff @(posedge core_clk)
    begin
        selfAnA_q <= selfAutoNeg;
        selfAnS_q <= selfAnA_q;
    end

    // soft full reset acts as a synchronous reset of the whole bank
    logic fullRst_q;
    wire logic rst = sys_rst || fullRst_q;

    // bus decode: byte address is four times the register index
    wire logic access = avs_read || avs_write;
    wire logic [5:0] idx = avs_address[7:2];
    wire logic hitCfg3 = (idx == pccr_pkg::CONFIG_THREE_IDX);
    wire logic hitSrst = (idx == pccr_pkg::SRST_IDX);
    wire logic hitTmch = (idx == pccr_pkg::TMCH_IDX);
    wire logic hitRxtm = (idx == pccr_pkg::RXTM_IDX);
    wire logic hitStat = (idx == pccr_pkg::IRQS_IDX);
    wire logic hitMask = (idx == pccr_pkg::IRQM_IDX);
    wire logic hitLink = (idx == pccr_pkg::LINK_IDX);
    wire logic mapped = hitCfg3 || hitSrst || hitTmch || hitRxtm ||
        hitStat || hitMask || hitLink;
    // one wait cycle: request accepted on the edge after waitrequest drops
    logic ack_q;
    wire logic take = access && ack_q;
    wire logic wr = take && avs_write;

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] wd, input logic [3:0] be, input logic [15:0] m);
        logic [15:0] bytes;
        bytes = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        merge16 = (bytes & m) | (old & ~m);
    endfunction

    // config_three writable bits; reserved and status bits kept out
    logic [15:0] config_three_q;
    wire logic [15:0] cfg3Wr = merge16(config_three_q, avs_writedata,
        avs_byteenable, pccr_pkg::CONFIG_THREE_WMASK);
    always_ff @(posedge core_clk)
    begin
        if (rst)
            config_three_q <= 16'h0;
        else if (wr && hitCfg3)
            config_three_q <= cfg3Wr;
    end
    wire logic extFd = config_three_q[pccr_pkg::EXT_FD_BIT];
    wire logic robustEn = config_three_q[pccr_pkg::ROBUST_BIT];
    wire logic quickEn = config_three_q[pccr_pkg::QUICK_BIT];
    wire logic irqOe = config_three_q[pccr_pkg::IRQ_OE_BIT];
    wire logic forceIrq = config_three_q[pccr_pkg::FORCE_IRQ_BIT];
    wire logic ctLaunch = wr && hitCfg3 && avs_byteenable[0] &&
        avs_writedata[pccr_pkg::CT_START_BIT];

    logic [15:0] tmch_q;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            tmch_q <= pccr_pkg::TMCH_RESET;
        else if (wr && hitTmch)
            tmch_q <= merge16(tmch_q, avs_writedata, avs_byteenable,
                pccr_pkg::TMCH_WMASK);
    end
    logic [15:0] rxtm_q;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            rxtm_q <= pccr_pkg::RXTM_RESET;
        else if (wr && hitRxtm)
            rxtm_q <= merge16(rxtm_q, avs_writedata, avs_byteenable,
                16'hffff);
    end

    // soft reset bits: pulse then clear; restart holds for a fixed time
    wire logic srstWr = wr && hitSrst && avs_byteenable[1];
    logic [4:0] restartCnt_q;
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || fullRst_q)
            fullRst_q <= 1'b0;
        else
            fullRst_q <= srstWr && avs_writedata[pccr_pkg::FULL_RST_BIT];
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
            restartCnt_q <= 5'h0;
        else if (srstWr && avs_writedata[pccr_pkg::RESTART_BIT])
            restartCnt_q <= 5'(pccr_pkg::RESTART_CYCLES);
        else if (restartCnt_q != 5'h0)
            restartCnt_q <= restartCnt_q - 5'h1;
    end
    wire logic restarting = (restartCnt_q != 5'h0);
    always_ff @(posedge core_clk)
    begin
        if (rst)
            phyRestart <= 1'b0;
        else
            phyRestart <= restarting;
    end
    // restart clears datapath state only; register bits stay untouched
    wire logic coreClr = rst || restarting;

    // cable test sequencer
    pccr_pkg::pccr_ct_state_t ctState_q;
    logic [15:0] ctCnt_q;
    logic ctFail_q;
    logic ctFaultSeen_q;
    always_ff @(posedge core_clk)
    begin
        if (coreClr)
            ctState_q <= pccr_pkg::CT_IDLE;
        else
            unique case (ctState_q)
                pccr_pkg::CT_IDLE:
                    if (ctLaunch)
                        ctState_q <= pccr_pkg::CT_RUN;
                pccr_pkg::CT_RUN:
                    if (ctCnt_q == 16'(CT_CYCLES - 1))
                        ctState_q <= pccr_pkg::CT_EVAL;
                pccr_pkg::CT_EVAL:
                    ctState_q <= pccr_pkg::CT_IDLE;
                default:
                    ctState_q <= pccr_pkg::CT_IDLE;
            endcase
    end
    always_ff @(posedge core_clk)
    begin
        if (coreClr || ctState_q != pccr_pkg::CT_RUN)
            ctCnt_q <= 16'h0;
        else
            ctCnt_q <= ctCnt_q + 16'h1;
    end
    always_ff @(posedge core_clk)
    begin
        if (coreClr || ctLaunch)
            ctFaultSeen_q <= 1'b0;
        else if (ctState_q == pccr_pkg::CT_RUN && faultS)
            ctFaultSeen_q <= 1'b1;
    end
    always_ff @(posedge core_clk)
    begin
        if (coreClr)
            ctFail_q <= 1'b0;
        else if (ctLaunch && ctState_q == pccr_pkg::CT_IDLE)
            ctFail_q <= 1'b0;
        else if (ctState_q == pccr_pkg::CT_EVAL)
            ctFail_q <= ctFaultSeen_q;
    end
    // done reads low from the launch edge until evaluation ends
    wire logic ctDone = (ctState_q == pccr_pkg::CT_IDLE);
    wire logic ctEnd = (ctState_q == pccr_pkg::CT_EVAL);

    // crossover and duplex engine
    logic xSettled;
    pccr_xover #(.MS_CYCLES(MS_CYCLES)) xover
    (
        .core_clk(core_clk),
        .clr(coreClr),
        .robustEn(robustEn),
        .quickEn(quickEn),
        .timerCode(rxtm_q[3:0]),
        .selfAutoNeg(selfAnS_q),
        .partnerForced100(pF100S),
        .partnerFullDuplex(pFdS),
        .extFd(extFd),
        .energySeen(energyS),
        .mdixSel(mdixSel),
        .fullDuplex(fullDuplex),
        .settled(xSettled)
    );
    logic xSettledD_q;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            xSettledD_q <= 1'b0;
        else
            xSettledD_q <= xSettled;
    end

    // sticky status, write one to clear; a new event wins over the clear
    logic [2:0] irqStat_q;
    logic [2:0] irqMask_q;
    wire logic [2:0] evNow = {xSettled && !xSettledD_q,
        ctEnd && ctFaultSeen_q, ctEnd};
    wire logic [2:0] w1c = (wr && hitStat && avs_byteenable[0])
        ? avs_writedata[2:0] : 3'h0;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            irqStat_q <= 3'h0;
        else
            irqStat_q <= (irqStat_q & ~w1c) | evNow;
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
            irqMask_q <= pccr_pkg::EV_MASK_RESET;
        else if (wr && hitMask && avs_byteenable[0])
            irqMask_q <= avs_writedata[2:0];
    end
    wire logic anyIrq = |(irqStat_q & irqMask_q) || |srcS;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irqStat_q & irqMask_q);
    end

    // shared pin: open-drain active-low interrupt or power-down input
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            irqOrPowerdownOe <= 1'b0;
            irqOrPowerdownOut <= 1'b0;
            powerDown <= 1'b0;
        end
        else
        begin
            irqOrPowerdownOe <= irqOe && (forceIrq || anyIrq);
            irqOrPowerdownOut <= 1'b0;
            powerDown <= !irqOe && !pinInS;
        end
    end

    // test channel enables
    wire logic [3:0] oneCh = 4'h1 << tmch_q[6:5];
    always_ff @(posedge core_clk)
    begin
        if (rst)
            testChannelEn <= 4'h0;
        else
            testChannelEn <= tmch_q[pccr_pkg::TM_ALL_BIT] ? 4'hf : oneCh;
    end

    // read mux; reserved bits come back as zero
    wire logic [15:0] cfg3Rd = config_three_q | {13'h0, ctFail_q, ctDone, 1'b0};
    wire logic [15:0] linkRd = {13'h0, xSettled, fullDuplex, mdixSel};
    wire logic [15:0] rdMux = hitCfg3 ? cfg3Rd
        : hitTmch ? tmch_q
        : hitRxtm ? rxtm_q
        : hitStat ? {13'h0, irqStat_q}
        : hitMask ? {13'h0, irqMask_q}
        : hitLink ? linkRd
        : 16'h0;
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ack_q <= 1'b0;
            avs_readdata <= 32'h0;
            avs_response_err <= 1'b0;
        end
        else
        begin
            ack_q <= access && !ack_q;
            if (access && !ack_q)
            begin
                avs_readdata <= avs_read ? {16'h0, rdMux} : 32'h0;
                avs_response_err <= !mapped;
            end
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !(access && !ack_q);
    end
endmodule

// >>> src/pccr_xover.sv
// crossover and duplex resolution engine: on each timer expiry it flips
// the mdi/mdix choice until a link indication arrives.
// assumes link inputs already synchronised to core_clk.
`timescale 1ns/1ps
module pccr_xover
#(
    parameter int MS_CYCLES = pccr_pkg::CYC_PER_MS
)
(
    input wire logic core_clk,
    input wire logic clr,
    input wire logic robustEn,
    input wire logic quickEn,
    input wire logic [3:0] timerCode,
    input wire logic selfAutoNeg,
    input wire logic partnerForced100,
    input wire logic partnerFullDuplex,
    input wire logic extFd,
    input wire logic energySeen,
    output logic mdixSel,
    output logic fullDuplex,
    output logic settled
);
    logic msTick;
    logic [8:0] msCnt_q;
    pccr_tick_div #(.DIV(MS_CYCLES)) msDiv
    (
        .core_clk(core_clk),
        .clr(clr),
        .tick(msTick)
    );
    // robust timer length: (code+1) steps of 32 ms; quick mode uses 1 step
    wire logic [8:0] periodMs = robustEn
        ? 9'((timerCode + 5'h1) * pccr_pkg::TIMER_STEP_MS)
        : (quickEn ? 9'(pccr_pkg::TIMER_STEP_MS)
                   : 9'(pccr_pkg::TIMER_STEP_MS * 2));
    // a forced-100 partner against local autoneg deadlocks without robust mode
    wire logic unsupported = partnerForced100 && selfAutoNeg;
    wire logic canHunt = robustEn || !unsupported;
    wire logic expire = msTick && (msCnt_q >= periodMs - 9'h1);
    always_ff @(posedge core_clk)
    begin
        if (clr || settled || !canHunt || expire)
            msCnt_q <= 9'h0;
        else if (msTick)
            msCnt_q <= msCnt_q + 9'h1;
    end
    always_ff @(posedge core_clk)
    begin
        if (clr)
            mdixSel <= 1'b0;
        else if (!settled && canHunt && expire)
            mdixSel <= !mdixSel;
    end
    always_ff @(posedge core_clk)
    begin
        if (clr)
            settled <= 1'b0;
        else
            settled <= energySeen;
    end
    // extended duplex forces full against a forced-100 partner
    wire logic fdNext = (extFd && partnerForced100) ? 1'b1
        : (partnerForced100 ? partnerFullDuplex && !selfAutoNeg
                            : partnerFullDuplex);
    always_ff @(posedge core_clk)
    begin
        if (clr)
            fullDuplex <= 1'b0;
        else
            fullDuplex <= fdNext;
    end
endmodule

// >>> test/pccr_bench.sv
// self-checking bench: bus traffic through the controller model,
// link and pad levels driven here; short timer counts for speed
`timescale 1ns/1ps
module pccr_bench;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable, testChannelEn;
    logic avs_read, avs_write, avs_waitrequest, avs_response_err;
    logic irqOrPowerdownIn, irqOrPowerdownOut, irqOrPowerdownOe;
    logic powerDown, mdixSel, fullDuplex, phyRestart, irq, timedOut;
    logic cableFault = 1'b0;
    logic selfAutoNeg = 1'b1;
    logic partnerForced100 = 1'b0;
    logic partnerFullDuplex = 1'b0;
    logic energySeen = 1'b0;
    logic pinPullDn = 1'b0;
    logic [2:0] irqSources = 3'h0;
    logic [15:0] q;
    int error_cnt = 0;
    int samples_checked = 0;
    always #5 core_clk = ~core_clk;
    // open-drain pad with pull-up; the bench may pull it low
    assign irqOrPowerdownIn = !(irqOrPowerdownOe && !irqOrPowerdownOut)
        && !pinPullDn;
    pccr_top #(.MS_CYCLES(10), .CT_CYCLES(20)) i_dut
    (
        .core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .avs_response_err, .irqOrPowerdownIn, .irqOrPowerdownOut,
        .irqOrPowerdownOe, .powerDown, .cableFault, .selfAutoNeg,
        .partnerForced100, .partnerFullDuplex, .energySeen, .irqSources,
        .testChannelEn, .mdixSel, .fullDuplex, .phyRestart, .irq
    );
    pccr_mgmt_model i_mgmt
    (
        .core_clk, .avs_waitrequest, .avs_readdata, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .timedOut
    );
    task automatic final_report();
        if (timedOut === 1'b1)
            error_cnt++;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_mgmt.xfer(1'b1, a, d, q);
        if (timedOut === 1'b1)
            final_report();
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        i_mgmt.xfer(1'b0, a, 16'h0000, q);
        if (timedOut === 1'b1)
            final_report();
        check(q, exp);
    endtask
    task automatic poll(input logic [7:0] a, input logic [15:0] m);
        int c;
        c = 0;
        q = 16'h0000;
        while ((q & m) !== m && c < 1000 && timedOut !== 1'b1)
        begin
            i_mgmt.xfer(1'b0, a, 16'h0000, q);
            c++;
        end
        if (c >= 1000 || timedOut === 1'b1)
        begin
            error_cnt++;
            final_report();
        end
    endtask
    // cycles between two flips of the crossover choice
    task automatic period(input int exp);
        int c;
        logic m;
        repeat (3)
        begin
            m = mdixSel;
            c = 0;
            while (mdixSel === m && c < 4000)
            begin
                @(posedge core_clk);
                c++;
            end
            if (c >= 4000)
            begin
                error_cnt++;
                final_report();
            end
        end
        check(16'(c >= exp - 2 && c <= exp + 2), 16'h0001);
    endtask
    task automatic link(input logic [15:0] cfg, input logic fd);
        energySeen <= 1'b0;
        wr(8'h78, cfg);
        tick(4);
        energySeen <= 1'b1;
        poll(8'hc0, 16'h0004);
        tick(2);
        check({15'h0, fullDuplex}, {15'h0, fd});
    endtask
    initial
    begin
        tick(5);
        sys_rst <= 1'b0;
        tick(3);
        check({12'h0, testChannelEn}, 16'h0001);
        rd(8'h78, 16'h0002);
        rd(8'hb0, 16'h141f);
        rd(8'h94, 16'h0400);
        wr(8'h78, 16'hfffe);
        rd(8'h78, 16'h0bc2);
        wr(8'h7c, 16'h3fff);
        rd(8'h7c, 16'h0000);
        wr(8'h94, 16'hffff);
        rd(8'h94, 16'hffe0);
        wr(8'h00, 16'hffff);
        rd(8'h00, 16'h0000);
        $display("reset and reserved test done");
        tick(3);
        check({15'h0, irqOrPowerdownOe}, 16'h0001);
        wr(8'h78, 16'h0080);
        tick(3);
        check({15'h0, irqOrPowerdownOe}, 16'h0000);
        irqSources <= 3'h4;
        tick(5);
        check({15'h0, irqOrPowerdownOe}, 16'h0001);
        irqSources <= 3'h0;
        wr(8'h78, 16'h0000);
        pinPullDn <= 1'b1;
        tick(6);
        check({15'h0, powerDown}, 16'h0001);
        wr(8'h78, 16'h0080);
        tick(4);
        check({15'h0, powerDown}, 16'h0000);
        pinPullDn <= 1'b0;
        $display("pad test done");
        for (int s = 0; s < 8; s++)
        begin
            wr(8'h94, {8'h04, s[2:0], 5'h00});
            tick(3);
            check({12'h0, testChannelEn},
                s[2] ? 16'h000f : 16'(4'h1 << s[1:0]));
        end
        $display("channel test done");
        cableFault <= 1'b1;
        wr(8'h78, 16'h0001);
        rd(8'h78, 16'h0000);
        poll(8'h78, 16'h0002);
        rd(8'h78, 16'h0006);
        cableFault <= 1'b0;
        wr(8'h78, 16'h0001);
        rd(8'h78, 16'h0000);
        poll(8'h78, 16'h0002);
        rd(8'h78, 16'h0002);
        // status holds done and fail; mask starts closed
        check({15'h0, irq}, 16'h0000);
        wr(8'hc8, 16'h0002);
        tick(3);
        check({15'h0, irq}, 16'h0001);
        rd(8'hc4, 16'h0003);
        wr(8'hc4, 16'h0003);
        tick(3);
        check({15'h0, irq}, 16'h0000);
        rd(8'hc4, 16'h0000);
        $display("cable test done");
        // autoneg against forced 100: only robust mode keeps hunting
        partnerForced100 <= 1'b1;
        for (int c = 0; c < 3; c++)
        begin
            i_mgmt.robust_timer(4'(c));
            period(320 * (c + 1));
        end
        rd(8'hb0, 16'h1412);
        selfAutoNeg <= 1'b0;
        wr(8'h78, 16'h0100);
        period(320);
        wr(8'h78, 16'h0000);
        period(640);
        $display("crossover test done");
        selfAutoNeg <= 1'b1;
        link(16'h0800, 1'b1);
        wr(8'h7c, 16'h4000);
        tick(3);
        check({15'h0, phyRestart}, 16'h0001);
        tick(20);
        rd(8'h78, 16'h0802);
        link(16'h0000, 1'b0);
        wr(8'h78, 16'h0b80);
        wr(8'h7c, 16'h8000);
        tick(4);
        rd(8'h78, 16'h0002);
        rd(8'h94, 16'h0400);
        rd(8'h7c, 16'h0000);
        rd(8'hb0, 16'h141f);
        $display("duplex and reset test done");
        final_report();
    end
endmodule
bind pccr_top pccr_top_asserts u_chk
(
    .core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .avs_response_err,
    .irqOrPowerdownOut, .irqOrPowerdownOe, .powerDown, .phyRestart
);

// >>> test/pccr_mgmt_model.sv
// management controller: avalon-mm master, one transfer per call
// assumes the slave answers by dropping waitrequest; waits are bounded
`timescale 1ns/1ps
module pccr_mgmt_model
(
    input wire logic core_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    output logic timedOut
);
    initial
    begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h3;
        timedOut = 1'b0;
    end
    // request held until waitrequest is sampled low at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= !w;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 64)
        begin
            @(posedge core_clk);
            n++;
        end
        q = avs_readdata[15:0];
        if (n >= 64)
            timedOut = 1'b1;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // timer code only counts once robust mode is on, so that goes first
    task automatic robust_timer(input logic [3:0] code);
        logic [15:0] q;
        xfer(1'b1, 8'h78, 16'h0200, q);
        xfer(1'b1, 8'hb0, {12'h141, code}, q);
    endtask
endmodule

// >>> test/pccr_top_asserts.sv
// assertions on bus answers, pad roles and the restart pulse
// bound to pccr_top from the bench; sees the top's ports only
`timescale 1ns/1ps
module pccr_top_asserts
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic avs_response_err,
    input wire logic irqOrPowerdownOut,
    input wire logic irqOrPowerdownOe,
    input wire logic powerDown,
    input wire logic phyRestart
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    logic [5:0] idx;
    logic rdEnd, anyEnd, mapped;
    logic [4:0] restartCnt_q;
    assign idx = avs_address[7:2];
    assign anyEnd = !avs_waitrequest && (avs_read || avs_write);
    assign rdEnd = !avs_waitrequest && avs_read;
    assign mapped = idx inside {6'h1e, 6'h1f, 6'h25, 6'h2c, 6'h30,
        6'h31, 6'h32};
    // a counter, since the pulse is too long for a repetition
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !phyRestart)
            restartCnt_q <= 5'h00;
        else
            restartCnt_q <= restartCnt_q + 5'h01;
    end
    AST_ONE_WAIT: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for two cycles");
    AST_ERR_MAP: assert property (anyEnd |-> avs_response_err == !mapped)
        else $error("error response disagrees with the map");
    AST_RD_UPPER: assert property (rdEnd |-> avs_readdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    AST_CFG_RSV: assert property (rdEnd && idx == 6'h1e |->
        (avs_readdata & 32'h0000_0439) == 32'h0)
        else $error("reserved or start bit of config reads one");
    AST_SRST_ZERO: assert property (rdEnd && idx == 6'h1f |->
        avs_readdata == 32'h0) else $error("reset register not zero");
    AST_TMCH_LOW: assert property (rdEnd && idx == 6'h25 |->
        avs_readdata[4:0] == 5'h00) else $error("channel low bits set");
    AST_PAD_ROLE: assert property (powerDown |-> !irqOrPowerdownOe)
        else $error("pad used as input and output at once");
    AST_PAD_LOW: assert property (irqOrPowerdownOe |->
        !irqOrPowerdownOut) else $error("pad driven high");
    AST_RESTART_LEN: assert property ($fell(phyRestart) |->
        restartCnt_q == 5'h10) else $error("restart pulse not 16 cycles");
endmodule
